//--- e1mon_pkg.sv
package e1mon_pkg;
	// register offsets; printed offsets are not word multiples, so they are
	// indices and the byte address is four times the index
	localparam logic [7:0] E1MON_IDX_SPARE = 8'h29;
	localparam logic [7:0] E1MON_IDX_CRC_LO = 8'h2A;
	localparam logic [7:0] E1MON_IDX_CRC_HI = 8'h2B;
	localparam logic [7:0] E1MON_IDX_ALARM = 8'h2C;
	// field positions
	localparam int E1MON_HI_OVR_BIT = 7;
	localparam int E1MON_HI_FRESH_BIT = 6;
	localparam int E1MON_AL_IRQE_BIT = 6;
	localparam int E1MON_AL_CHG_BIT = 5;
	localparam int E1MON_AL_STAT_BIT = 4;
	// alarm integration thresholds
	localparam logic [4:0] E1MON_ALARM_SET_CNT = 5'h16;
	localparam logic [4:0] E1MON_ALARM_CLR_CNT = 5'h00;
	// timing
	localparam int E1MON_CLK_HZ = 100000000;
	localparam int E1MON_SECOND_S = 1;
	localparam int E1MON_SECOND_CYC = E1MON_CLK_HZ * E1MON_SECOND_S;
	localparam int E1MON_FRAME_NS = 125000;
	localparam int E1MON_FRAME_CYC = E1MON_FRAME_NS / 10;
	localparam logic [9:0] E1MON_CRC_MAX = 10'h3FF;
endpackage : e1mon_pkg

//--- e1mon_tick.sv
`timescale 1ns/1ps
`default_nettype none
// free-running period divider: one-cycle pulse every PERIOD cycles
module e1mon_tick #(
	parameter int PERIOD = 1000
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	output logic tick // one-cycle pulse
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} e1mon_tick_st_t;
	e1mon_tick_st_t st_r, st_nxt;
	// count down; pulse on reload
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == 32'h0) begin
			st_nxt.cnt = 32'(PERIOD - 1);
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt - 32'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		// preload so the first pulse closes a whole period, not one cycle
		if (!presetn) begin
			st_r <= '{cnt: 32'(PERIOD - 1), tick: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign tick = st_r.tick;
endmodule : e1mon_tick
`default_nettype wire

//--- e1mon_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a group of level inputs
module e1mon_sync #(
	parameter int W = 1
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic [W-1:0] d, // asynchronous in
	output logic [W-1:0] q // synchronised out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} e1mon_sync_st_t;
	e1mon_sync_st_t st_r, st_nxt;
	// first stage feeds only the second
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
endmodule : e1mon_sync
`default_nettype wire

//--- e1mon_top.sv
// Contract
// - capture ts16 frame0 bits five to eight
// - refresh spare bits once per multiframe
// - ten-bit crc count, low byte, per second
// - high register: count9:8, overrun, fresh flag
// - second boundary transfers count, sets fresh
// - overrun when unread count overwritten
// - one-second period generated internally
// - detect two all-ones ts16 bytes while unaligned
// - detect interval increments; declare at 22
// - quiet interval decrements; withdraw at zero
// - alarm sets and clears after about 3ms
// - enabled interrupt on alarm status change
// - change flag set on change, read clears
// - crc mismatch event counts one error
// - multiframe-lost qualifies detection
`timescale 1ns/1ps
`default_nettype none
module e1mon_top
	import e1mon_pkg::*;
#(
	parameter int SECOND_CYC = e1mon_pkg::E1MON_SECOND_CYC,
	parameter int INTERVAL_CYC = e1mon_pkg::E1MON_FRAME_CYC
) (
	input wire logic pclk, // apb clock, also line-rate domain
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [7:0] ts16_byte, // slot 16 byte, bit1 at msb
	input wire logic ts16_valid, // pulse: ts16_byte present
	input wire logic mf_frame0, // level: current frame is frame 0
	input wire logic sig_multiframe_lost, // level: mf alignment lost
	input wire logic crc_error, // pulse: submultiframe crc mismatch
	output logic slot16_alarm_irq // alarm change interrupt, level
);
	import e1mon_pkg::*;

	typedef struct packed {
		logic [3:0] spare;
		logic [9:0] acc;
		logic [9:0] held;
		logic fresh;
		logic count_overrun_flag;
		logic prev_ones;
		logic det_seen;
		logic [4:0] icnt;
		logic status;
		logic chg;
		logic irqe;
		logic irq;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} e1mon_st_t;

	e1mon_st_t st_r, st_nxt;
	logic sec_tick;
	logic int_tick;
	logic lost_s;
	logic [9:0] word_idx;
	logic rd_acc;
	logic wr_acc;
	logic all_ones;
	logic detect;
	logic mapped;

	// the lost level comes from the framer's own clock; treat it as foreign
	e1mon_sync #(.W(1)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(sig_multiframe_lost),
		.q(lost_s)
	);

	// internal second, independent of any software transfer
	e1mon_tick #(.PERIOD(SECOND_CYC)) u_sec (
		.pclk(pclk),
		.presetn(presetn),
		.tick(sec_tick)
	);

	// integration interval, one frame by default
	e1mon_tick #(.PERIOD(INTERVAL_CYC)) u_int (
		.pclk(pclk),
		.presetn(presetn),
		.tick(int_tick)
	);

	// access phase decode; registers sit at four times their index
	assign word_idx = paddr[11:2];
	assign rd_acc = psel && penable && !pwrite && !st_r.ready;
	assign wr_acc = psel && penable && pwrite && !st_r.ready;
	assign all_ones = (ts16_byte == 8'hFF);
	assign detect = ts16_valid && all_ones && st_r.prev_ones && lost_s;
	assign mapped = (word_idx == 10'(E1MON_IDX_SPARE)) ||
		(word_idx == 10'(E1MON_IDX_CRC_LO)) ||
		(word_idx == 10'(E1MON_IDX_CRC_HI)) ||
		(word_idx == 10'(E1MON_IDX_ALARM));

	// whole next-state in one process
	always_comb begin
		st_nxt = st_r;
		st_nxt.ready = 1'b0;
		st_nxt.err = 1'b0;
		// spare bits: ts16 bits 5..8 sit in byte bits 3..0
		if (ts16_valid && mf_frame0) begin
			st_nxt.spare = ts16_byte[3:0];
		end
		// crc accumulator saturates and restarts after transfer
		if (sec_tick) begin
			st_nxt.held = st_r.acc;
			st_nxt.acc = crc_error ? 10'h001 : 10'h000;
			st_nxt.fresh = 1'b1;
			if (st_r.fresh) begin
				st_nxt.count_overrun_flag = 1'b1;
			end
		end else if (crc_error && st_r.acc != E1MON_CRC_MAX) begin
			st_nxt.acc = st_r.acc + 10'h001;
		end
		// consecutive all-ones tracking; only bytes seen while lost count
		if (ts16_valid) begin
			st_nxt.prev_ones = all_ones && lost_s;
		end
		if (detect) begin
			st_nxt.det_seen = 1'b1;
		end
		// up/down interval integrator
		if (int_tick) begin
			st_nxt.det_seen = detect;
			if (st_r.det_seen || detect) begin
				if (st_r.icnt != E1MON_ALARM_SET_CNT) begin
					st_nxt.icnt = st_r.icnt + 5'h01;
				end
			end else if (st_r.icnt != E1MON_ALARM_CLR_CNT) begin
				st_nxt.icnt = st_r.icnt - 5'h01;
			end
		end
		// declare at the set count, withdraw at zero (22 frames ~ 3ms)
		if (st_r.icnt == E1MON_ALARM_SET_CNT) begin
			st_nxt.status = 1'b1;
		end else if (st_r.icnt == E1MON_ALARM_CLR_CNT) begin
			st_nxt.status = 1'b0;
		end
		// register reads and the flags they clear
		if (psel && penable && !st_r.ready) begin
			st_nxt.ready = 1'b1;
			st_nxt.err = !mapped;
			st_nxt.rdata = 32'h0;
		end
		if (rd_acc) begin
			if (word_idx == 10'(E1MON_IDX_SPARE)) begin
				st_nxt.rdata = {28'h0, st_r.spare};
			end else if (word_idx == 10'(E1MON_IDX_CRC_LO)) begin
				st_nxt.rdata = {24'h0, st_r.held[7:0]};
			end else if (word_idx == 10'(E1MON_IDX_CRC_HI)) begin
				st_nxt.rdata = {24'h0, st_r.count_overrun_flag, st_r.fresh, 4'h0,
					st_r.held[9:8]};
				// set wins over the read clear
				st_nxt.fresh = sec_tick;
				st_nxt.count_overrun_flag = sec_tick && st_r.fresh;
			end else if (word_idx == 10'(E1MON_IDX_ALARM)) begin
				st_nxt.rdata = {24'h0, 1'b0, st_r.irqe, st_r.chg,
					st_r.status, 4'h0};
				st_nxt.chg = 1'b0;
			end
		end
		if (wr_acc && word_idx == 10'(E1MON_IDX_ALARM)) begin
			st_nxt.irqe = pwdata[E1MON_AL_IRQE_BIT];
		end
		// a change in the same cycle as the read still lands
		if (st_nxt.status != st_r.status) begin
			st_nxt.chg = 1'b1;
		end
		st_nxt.irq = st_nxt.chg && st_nxt.irqe;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.err;
	assign slot16_alarm_irq = st_r.irq;

	// alarm follows the counter one cycle after either end point
	alarm_set_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.icnt == E1MON_ALARM_SET_CNT |=> st_r.status)
		else $error("alarm not declared at set count");
	alarm_clr_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.icnt == E1MON_ALARM_CLR_CNT |=> !st_r.status)
		else $error("alarm not withdrawn at zero");
	// between the end points the alarm must not move
	status_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.icnt != E1MON_ALARM_SET_CNT &&
		st_r.icnt != E1MON_ALARM_CLR_CNT |=> $stable(st_r.status))
		else $error("alarm moved between end points");
	// integrator steps once per interval and stays in range
	icnt_step_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		int_tick && !detect && !st_r.det_seen && st_r.icnt != 5'h00 |=>
		st_r.icnt == $past(st_r.icnt) - 5'h01)
		else $error("counter not decremented");
	icnt_up_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		int_tick && (detect || st_r.det_seen) &&
		st_r.icnt != E1MON_ALARM_SET_CNT |=>
		st_r.icnt == $past(st_r.icnt) + 5'h01)
		else $error("counter not incremented");
	icnt_range_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.icnt <= E1MON_ALARM_SET_CNT)
		else $error("counter beyond set count");
	icnt_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!int_tick |=> $stable(st_r.icnt))
		else $error("counter moved inside an interval");
	// a qualified pair of all-ones bytes marks the current interval
	det_latch_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		ts16_valid && all_ones && st_r.prev_ones && lost_s |=>
		st_r.det_seen)
		else $error("detection not recorded");
	// change flag: set on any move, cleared only by an alarm read
	chg_flag_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		$changed(st_r.status) |-> st_r.chg)
		else $error("change flag missed");
	chg_clear_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_ALARM) |=>
		st_r.chg == $changed(st_r.status))
		else $error("change flag not cleared by read");
	chg_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.chg && !rd_acc |=> st_r.chg)
		else $error("change flag lost without read");
	// interrupt is the enabled change flag; enable moves only on write
	irq_out_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		slot16_alarm_irq == (st_r.chg && st_r.irqe))
		else $error("irq not gated by enable");
	irqe_write_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		wr_acc && word_idx == 10'(E1MON_IDX_ALARM) |=>
		st_r.irqe == $past(pwdata[E1MON_AL_IRQE_BIT]))
		else $error("enable not written");
	irqe_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!wr_acc |=> $stable(st_r.irqe))
		else $error("enable moved without write");
	// second boundary: transfer, flags, and the accumulator restart
	fresh_set_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		sec_tick |=> st_r.fresh && st_r.held == $past(st_r.acc))
		else $error("transfer missing");
	ovr_set_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		sec_tick && st_r.fresh |=> st_r.count_overrun_flag)
		else $error("overrun missed");
	fresh_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.fresh && !rd_acc |=> st_r.fresh)
		else $error("fresh flag lost without read");
	ovr_only_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!st_r.count_overrun_flag && !(sec_tick && st_r.fresh) |=> !st_r.count_overrun_flag)
		else $error("overrun without unread transfer");
	flags_clear_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_CRC_HI) && !sec_tick |=>
		!st_r.fresh && !st_r.count_overrun_flag)
		else $error("count flags not cleared by read");
	// accumulator: counts each event, saturates, restarts on transfer
	acc_sat_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		st_r.acc == E1MON_CRC_MAX && !sec_tick |=>
		st_r.acc == E1MON_CRC_MAX)
		else $error("accumulator wrapped");
	acc_restart_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		sec_tick |=> st_r.acc == ($past(crc_error) ? 10'h001 : 10'h000))
		else $error("accumulator not restarted");
	acc_count_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!sec_tick && crc_error && st_r.acc != E1MON_CRC_MAX |=>
		st_r.acc == $past(st_r.acc) + 10'h001)
		else $error("crc error not counted");
	acc_idle_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!sec_tick && !crc_error |=> $stable(st_r.acc))
		else $error("accumulator moved without error");
	held_hold_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		!sec_tick |=> $stable(st_r.held))
		else $error("readable count moved mid-second");
	sec_pulse_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		sec_tick |=> !sec_tick)
		else $error("second boundary longer than a cycle");
	// register reads return the state seen at the accepting edge
	spare_cap_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		ts16_valid && mf_frame0 |=> st_r.spare == $past(ts16_byte[3:0]))
		else $error("spare bits not captured");
	rd_spare_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_SPARE) |=>
		prdata == {28'h0, $past(st_r.spare)})
		else $error("spare read data wrong");
	rd_lo_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_CRC_LO) |=>
		prdata == {24'h0, $past(st_r.held[7:0])})
		else $error("low count read data wrong");
	rd_hi_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_CRC_HI) |=>
		prdata == {24'h0, $past(st_r.count_overrun_flag), $past(st_r.fresh), 4'h0,
		$past(st_r.held[9:8])})
		else $error("high count read data wrong");
	rd_alarm_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		rd_acc && word_idx == 10'(E1MON_IDX_ALARM) |=>
		prdata[6:4] == {$past(st_r.irqe), $past(st_r.chg),
		$past(st_r.status)})
		else $error("alarm read data wrong");
	// bus answer: one wait state, a one-cycle ready, error if unmapped
	ready_next_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("access not answered");
	ready_pulse_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");
	err_map_a: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && penable && !pready |=> pslverr == !$past(mapped))
		else $error("error flag does not follow the map");
endmodule : e1mon_top
`default_nettype wire

//--- e1mon_frame_src.sv
`timescale 1ns/1ps
`default_nettype none
// framer core stand-in: slot 16 strobes, frame 0 marker, alignment state
module e1mon_frame_src (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic all_ones, // send ff in every slot 16
	input wire logic lost, // multiframe alignment state to report
	input wire logic [3:0] spare, // spare bits for frame 0
	output logic [7:0] ts16_byte, // slot 16 byte
	output logic ts16_valid, // byte strobe
	output logic mf_frame0, // frame 0 marker
	output logic sig_multiframe_lost // alignment lost
);
	logic [6:0] cyc_r; // 8 cycles a frame, 16 frames a multiframe

	// short frames keep the run brief; rates are scaled, not exact
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cyc_r <= 7'h00;
		else
			cyc_r <= cyc_r + 7'h01;
	end
	assign ts16_valid = presetn && (cyc_r[2:0] == 3'h0);
	assign mf_frame0 = (cyc_r[6:3] == 4'h0);
	assign sig_multiframe_lost = lost;
	// off the strobe the byte churns so a stale value is never trusted
	always_comb begin
		if (!ts16_valid)
			ts16_byte = {cyc_r, 1'b1} ^ 8'hA5;
		else if (all_ones)
			ts16_byte = 8'hFF;
		else if (mf_frame0)
			ts16_byte = {4'h0, spare};
		else
			ts16_byte = {1'b0, cyc_r};
	end
endmodule : e1mon_frame_src
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import e1mon_pkg::*;
	localparam logic [32:0] ALL = {33{1'b1}};
	localparam logic [32:0] ERR = {1'b1, 32'h0};
	logic pclk, presetn, psel, penable, pwrite, crc_error, all_ones, lost;
	logic pready, pslverr, irq, valid, frame0, mf_lost;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] tbyte;
	logic [3:0] spare;
	logic [32:0] last_rd;
	logic [32:0] q_exp[$];
	logic [32:0] q_msk[$];
	int miscompares, cmp_count, seed, k, i;

	e1mon_top #(.SECOND_CYC(1100), .INTERVAL_CYC(20)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ts16_byte(tbyte), .ts16_valid(valid),
		.mf_frame0(frame0), .sig_multiframe_lost(mf_lost),
		.crc_error(crc_error), .slot16_alarm_irq(irq));
	e1mon_frame_src u_src (.pclk(pclk), .presetn(presetn),
		.all_ones(all_ones), .lost(lost), .spare(spare), .ts16_byte(tbyte),
		.ts16_valid(valid), .mf_frame0(frame0), .sig_multiframe_lost(mf_lost));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic finish_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [32:0] e, m, s);
		if (m !== 33'h0) begin
			cmp_count++;
			if (((s ^ e) & m) !== 33'h0) begin
				miscompares++;
				$display("MISMATCH %s exp %h seen %h", nm, e, s);
			end
		end
	endtask : chk

	// one apb transfer; the answer is judged by the monitor below
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd, input logic [32:0] e, input logic [32:0] m);
		q_exp.push_back(e);
		q_msk.push_back(m);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// poll until a one-second transfer shows; each poll clears the flag
	task automatic wait_fresh;
		do
			apb(1'b0, E1MON_IDX_CRC_HI, 32'h0, 33'h0, 33'h0);
		while (last_rd[6] !== 1'b1);
	endtask : wait_fresh

	// monitor: oldest note against each answer
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			last_rd = {pslverr, prdata};
			chk("apb", q_exp.pop_front(), q_msk.pop_front(), last_rd);
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		finish_test();
	end

	initial begin
		seed = 33280;
		{presetn, psel, penable, pwrite, crc_error, all_ones, lost} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		spare = 4'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h0, ALL);
		apb(1'b0, E1MON_IDX_CRC_HI, 32'h0, 33'h0, ALL);
		apb(1'b0, 8'h2D, 32'h0, ERR, ALL);
		for (i = 0; i < 3; i++) begin
			spare <= 4'($random(seed));
			repeat (140) @(posedge pclk);
			apb(1'b1, E1MON_IDX_SPARE, 32'hFF, 33'h0, ERR);
			apb(1'b0, E1MON_IDX_SPARE, 32'h0, {29'h0, spare}, ALL);
			apb(1'b0, E1MON_IDX_SPARE, 32'h0, {29'h0, spare}, ALL);
		end
		// burst of back-to-back errors inside one second
		wait_fresh();
		k = 1 + ($unsigned($random(seed)) % 40);
		crc_error <= 1'b1;
		repeat (k) @(posedge pclk);
		crc_error <= 1'b0;
		wait_fresh();
		chk("crc_hi", 33'h40, ALL, last_rd);
		apb(1'b0, E1MON_IDX_CRC_LO, 32'h0, 33'(k), ALL);
		// over a thousand errors in one second saturate the count
		crc_error <= 1'b1;
		repeat (1050) @(posedge pclk);
		crc_error <= 1'b0;
		wait_fresh();
		chk("crc_sat", 33'h43, ALL, last_rd);
		apb(1'b0, E1MON_IDX_CRC_LO, 32'h0, 33'hFF, ALL);
		// two unread seconds, sampled mid-second
		repeat (2300) @(posedge pclk);
		apb(1'b0, E1MON_IDX_CRC_HI, 32'h0, 33'hC0, ALL);
		apb(1'b0, E1MON_IDX_CRC_HI, 32'h0, 33'h00, ALL);
		apb(1'b1, E1MON_IDX_ALARM, 32'h40, 33'h0, ERR);
		all_ones <= 1'b1;
		repeat (600) @(posedge pclk);
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h40, ALL);
		lost <= 1'b1;
		repeat (300) @(posedge pclk);
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h40, ALL);
		repeat (300) @(posedge pclk);
		chk("irq", 33'h1, 33'h1, {32'h0, irq});
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h70, ALL);
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h50, ALL);
		chk("irq", 33'h0, 33'h1, {32'h0, irq});
		apb(1'b1, E1MON_IDX_ALARM, 32'h0, 33'h0, ERR);
		all_ones <= 1'b0;
		repeat (300) @(posedge pclk);
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h10, ALL);
		repeat (300) @(posedge pclk);
		chk("irq", 33'h0, 33'h1, {32'h0, irq});
		apb(1'b0, E1MON_IDX_ALARM, 32'h0, 33'h20, ALL);
		finish_test();
	end
endmodule : tb
`default_nettype wire
